// >>> far_end_model.sv
// Far-end receiver that answers after a set number of detect attempts
module far_end_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       probe,
    input  wire logic [7:0] answer_after,
    output logic            far_end_found
);
    timeunit 1ns;
    timeprecision 1ps;
    int seen;
    // Zero means nothing attached; it also clears the attempt count
    always @(posedge clk or negedge reset_n)
        if (!reset_n || answer_after == 8'h00)
            seen <= 0;
        else if (probe)
            seen <= seen + 1;
    assign far_end_found = answer_after != 8'h00 && seen >= answer_after;
endmodule

// >>> lane_a_map.vh
// Register map and timing constants for the lane A receiver-detect block
// How it works
// - Status bit 0 reads 0 with signal present; valid only if strap floats.
// - Status bit 0 reads 1 on loss of signal.
// - Detect mode 00 holds input high-z; 11 applies 50 ohm at once.
// - Mode 01 probes every 12 ms, 50 attempts over 600 ms, then stops.
// - Mode 10 probes every 12 ms without limit until a receiver is found.
// - Auto modes keep high-z until detection, then switch to 50 ohm.
// - Override 1 uses register field; override 0 uses the dedicated pin.
// - Eight-bit equalizer boost field resets to 0x2F, 256 levels.
// - Bit 7 enables short-circuit protection; register resets to 0xED.
`ifndef LANE_A_MAP_VH
`define LANE_A_MAP_VH
`define ADDR_PIN_OVERRIDE   8'h08
`define ADDR_STATUS         8'h0A
`define ADDR_RESERVED_B     8'h0B
`define ADDR_RESERVED_C     8'h0C
`define ADDR_RECEIVER_DETECT_MODE_CTRL     8'h0E
`define ADDR_EQ_CTRL        8'h0F
`define ADDR_GEN_CTRL       8'h10
`define RST_PIN_OVERRIDE    8'h00
`define RST_RESERVED_B      8'h70
`define RST_RESERVED_C      8'h00
`define RST_RECEIVER_DETECT_MODE_CTRL      8'h00
`define RST_EQ_CTRL         8'h2F
`define RST_GEN_CTRL        8'hED
`define RST_SCP             1'b1
`define BIT_OVERRIDE_RECEIVER_DETECT_MODE  3
`define MODE_HI             3
`define MODE_LO             2
`define BIT_SCP             7
`define MODE_HIGHZ          2'h0
`define MODE_AUTO_BOUNDED   2'h1
`define MODE_AUTO_FOREVER   2'h2
`define MODE_FIXED_50       2'h3
`define PROBE_PERIOD_MS     12
`define PROBE_ATTEMPTS      50
`define CLK_KHZ             250000
`endif

// >>> lane_a_rxdetect_eq_regs.v
// Lane A configuration registers and receiver-detect state machine
`include "lane_a_map.vh"
module lane_a_rxdetect_eq_regs #(
    parameter PROBE_CYCLES = `PROBE_PERIOD_MS * `CLK_KHZ,
    parameter ATTEMPTS     = `PROBE_ATTEMPTS
) (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       wr_en,
    input  wire       rd_en,
    input  wire [7:0] addr,
    input  wire [7:0] wr_data,
    output reg  [7:0] rd_data,
    input  wire       signal_present,
    input  wire       strap_pin_float,
    input  wire [1:0] receiver_detect_pin,
    input  wire       far_end_found,
    output reg        probe,
    output reg        term_50_ohm,
    output reg  [7:0] eq_boost,
    output reg        short_protect_en
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_WAIT  = 2'h1;
    localparam ST_FOUND = 2'h2;
    localparam ST_DONE  = 2'h3;

    reg [7:0]  pin_override;
    reg [7:0]  reserved_cfg_b;
    reg [7:0]  reserved_cfg_c;
    reg [7:0]  lane_a_receiver_detect_ctrl;
    reg [7:0]  lane_a_equalizer_ctrl;
    reg [7:0]  lane_a_general_ctrl;
    reg [1:0]  state;
    reg [31:0] timer;
    reg [7:0]  attempts;
    reg [1:0]  mode_q;
    reg [1:0]  next_state;
    reg [31:0] next_timer;
    reg [7:0]  next_attempts;
    reg        next_probe;
    reg        next_term;
    wire [1:0] receiver_detect_mode;
    wire [7:0] status;

    assign receiver_detect_mode =
        lane_a_receiver_detect_ctrl[`MODE_HI:`MODE_LO];
    // Register field wins only when override is set
    wire [1:0] eff_mode = pin_override[`BIT_OVERRIDE_RECEIVER_DETECT_MODE] ?
        receiver_detect_mode : receiver_detect_pin;
    // Loss of signal reads 1; forced 0 when strap not floating
    assign status = {7'h00, strap_pin_float & ~signal_present};

    // Eight bits leave ample room above the attempt limit
    function [7:0] bump;
        input [7:0] count;
        begin
            bump = count + 8'h01;
        end
    endfunction

    // Last count of the timer closes one probe period
    function period_over;
        input [31:0] count;
        begin
            period_over = (count == PROBE_CYCLES - 1);
        end
    endfunction

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_override <= `RST_PIN_OVERRIDE;
            reserved_cfg_b <= `RST_RESERVED_B;
            reserved_cfg_c <= `RST_RESERVED_C;
            lane_a_receiver_detect_ctrl <= `RST_RECEIVER_DETECT_MODE_CTRL;
            lane_a_equalizer_ctrl <= `RST_EQ_CTRL;
            lane_a_general_ctrl <= `RST_GEN_CTRL;
            rd_data <= 8'h00;
        end
        else
        begin
            // Status and unmapped addresses drop writes
            if (wr_en)
            begin
                if (addr == `ADDR_PIN_OVERRIDE)
                    pin_override <= wr_data;
                else if (addr == `ADDR_RESERVED_B)
                    reserved_cfg_b <= wr_data;
                else if (addr == `ADDR_RESERVED_C)
                    reserved_cfg_c <= wr_data;
                else if (addr == `ADDR_RECEIVER_DETECT_MODE_CTRL)
                    lane_a_receiver_detect_ctrl <= wr_data;
                else if (addr == `ADDR_EQ_CTRL)
                    lane_a_equalizer_ctrl <= wr_data;
                else if (addr == `ADDR_GEN_CTRL)
                    lane_a_general_ctrl <= wr_data;
            end
            // A read beside a write returns the old value
            if (rd_en)
            begin
                if (addr == `ADDR_PIN_OVERRIDE)
                    rd_data <= pin_override;
                else if (addr == `ADDR_STATUS)
                    rd_data <= status;
                else if (addr == `ADDR_RESERVED_B)
                    rd_data <= reserved_cfg_b;
                else if (addr == `ADDR_RESERVED_C)
                    rd_data <= reserved_cfg_c;
                else if (addr == `ADDR_RECEIVER_DETECT_MODE_CTRL)
                    rd_data <= lane_a_receiver_detect_ctrl;
                else if (addr == `ADDR_EQ_CTRL)
                    rd_data <= lane_a_equalizer_ctrl;
                else if (addr == `ADDR_GEN_CTRL)
                    rd_data <= lane_a_general_ctrl;
                else
                    rd_data <= 8'h00;
            end
        end
    end

    // Mode change restarts detection from scratch
    always @*
    begin
        next_state = state;
        next_timer = timer;
        next_attempts = attempts;
        next_probe = 1'b0;
        next_term = term_50_ohm;
        if (mode_q != eff_mode)
        begin
            next_state = ST_IDLE;
            next_timer = 32'h0;
            next_attempts = 8'h00;
            next_term = (eff_mode == `MODE_FIXED_50);
        end
        // Fixed modes ignore the detect state entirely
        else if (eff_mode == `MODE_HIGHZ)
            next_term = 1'b0;
        else if (eff_mode == `MODE_FIXED_50)
            next_term = 1'b1;
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    next_term = 1'b0;
                    next_probe = 1'b1;
                    next_timer = 32'h0;
                    next_attempts = bump(attempts);
                    next_state = ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (far_end_found)
                    begin
                        next_state = ST_FOUND;
                        next_term = 1'b1;
                    end
                    else if (period_over(timer))
                    begin
                        if (eff_mode == `MODE_AUTO_BOUNDED &&
                            attempts == ATTEMPTS[7:0])
                            next_state = ST_DONE;
                        else
                        begin
                            // Probe again here so the period is exact
                            next_probe = 1'b1;
                            next_timer = 32'h0;
                            next_attempts = bump(attempts);
                        end
                    end
                    else
                        next_timer = timer + 32'h1;
                end
                ST_FOUND:
                    next_term = 1'b1;
                default:
                    next_term = 1'b0;
            endcase
        end
    end

    // Mode is held a cycle so that a change is seen as an edge
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_IDLE;
            timer <= 32'h0;
            attempts <= 8'h00;
            mode_q <= `MODE_HIGHZ;
            probe <= 1'b0;
            term_50_ohm <= 1'b0;
        end
        else
        begin
            state <= next_state;
            timer <= next_timer;
            attempts <= next_attempts;
            mode_q <= eff_mode;
            probe <= next_probe;
            term_50_ohm <= next_term;
        end
    end

    // Outputs copy the registers a cycle late, keeping them flop-driven
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            eq_boost <= `RST_EQ_CTRL;
            short_protect_en <= `RST_SCP;
        end
        else
        begin
            eq_boost <= lane_a_equalizer_ctrl;
            short_protect_en <= lane_a_general_ctrl[`BIT_SCP];
        end
    end
endmodule

// >>> lane_a_rxdetect_eq_regs_chk.sv
// Port assertions for the lane A register block
module lane_a_rxdetect_eq_regs_chk #(
    parameter int PROBE_CYCLES = 20,
    parameter int ATTEMPTS     = 50
) (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic       signal_present,
    input wire logic       strap_pin_float,
    input wire logic [1:0] receiver_detect_pin,
    input wire logic       far_end_found,
    input wire logic       probe,
    input wire logic       term_50_ohm,
    input wire logic [7:0] eq_boost,
    input wire logic       short_protect_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       ovr, scp, same;
    logic [1:0] mode, eff, eff_q;
    logic [7:0] eq;
    int         n, since;
    assign eff = ovr ? mode : receiver_detect_pin;
    assign same = eff == eff_q;
    // Attempt count restarts on every change of effective mode
    always @(posedge clk or negedge reset_n)
        if (!reset_n)
        begin
            {ovr, mode, eff_q, eq, scp, n} <= {5'h00, 8'h2F, 1'b1, 32'h0};
            since <= 0;
        end
        else
        begin
            ovr <= wr_en && addr == 8'h08 ? wr_data[3] : ovr;
            mode <= wr_en && addr == 8'h0E ? wr_data[3:2] : mode;
            eq <= wr_en && addr == 8'h0F ? wr_data : eq;
            scp <= wr_en && addr == 8'h10 ? wr_data[7] : scp;
            eff_q <= eff;
            n <= same ? n + probe : 0;
            since <= same && !probe ? since + 1 : 0;
        end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_st; rd_en && addr == 8'h0A |=>
        rd_data[0] == $past(strap_pin_float && !signal_present); endproperty
    a_st: assert property (p_st) else $error("status bit wrong");
    property p_hz; eff == 2'h0 [*3] |-> !term_50_ohm; endproperty
    a_hz: assert property (p_hz) else $error("not high-z");
    property p_50; eff == 2'h3 [*3] |-> term_50_ohm; endproperty
    a_50: assert property (p_50) else $error("not 50 ohm");
    property p_aut; $rose(term_50_ohm) && same && eff != 2'h3 |->
        $past(far_end_found); endproperty
    a_aut: assert property (p_aut) else $error("early 50 ohm");
    property p_cnt; probe && same && eff == 2'h1 |-> n < ATTEMPTS; endproperty
    a_cnt: assert property (p_cnt) else $error("extra attempt");
    property p_per; probe && same && n > 0 |-> since == PROBE_CYCLES - 1;
    endproperty
    a_per: assert property (p_per) else $error("attempt period");
    property p_gap; same && ^eff && !term_50_ohm && n > 0 &&
        (eff[1] || n < ATTEMPTS) |-> since < PROBE_CYCLES; endproperty
    a_gap: assert property (p_gap) else $error("attempt missing");
    property p_eq; !$past(wr_en) && !$past(wr_en, 2) |-> eq_boost == eq;
    endproperty
    a_eq: assert property (p_eq) else $error("boost wrong");
    property p_scp; !$past(wr_en) && !$past(wr_en, 2) |->
        short_protect_en == scp; endproperty
    a_scp: assert property (p_scp) else $error("protect wrong");
    c_bnd: cover property (probe && eff == 2'h1);
    c_fnd: cover property ($rose(term_50_ohm) && eff == 2'h2);
    c_st: cover property (rd_en && addr == 8'h0A && rd_data[0]);
endmodule
bind lane_a_rxdetect_eq_regs lane_a_rxdetect_eq_regs_chk #(
    .PROBE_CYCLES(PROBE_CYCLES),
    .ATTEMPTS    (ATTEMPTS)
) chk_i (
    .clk                 (clk),
    .reset_n             (reset_n),
    .wr_en               (wr_en),
    .rd_en               (rd_en),
    .addr                (addr),
    .wr_data             (wr_data),
    .rd_data             (rd_data),
    .signal_present      (signal_present),
    .strap_pin_float     (strap_pin_float),
    .receiver_detect_pin (receiver_detect_pin),
    .far_end_found       (far_end_found),
    .probe               (probe),
    .term_50_ohm         (term_50_ohm),
    .eq_boost            (eq_boost),
    .short_protect_en    (short_protect_en)
);

// >>> lane_a_rxdetect_eq_regs_tb.sv
// Self-checking bench for the lane A register block
module lane_a_rxdetect_eq_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, wr_en, rd_en, signal_present, strap_pin_float;
    logic far_end_found, probe, term_50_ohm, short_protect_en;
    logic [7:0] addr, wr_data, rd_data, eq_boost, answer_after;
    logic [1:0] receiver_detect_pin;
    logic [7:0] m [logic [7:0]];
    logic [31:0] lf = 32'hB6942323;
    int num_errors, compares, cyc, probes;
    lane_a_rxdetect_eq_regs #(
        .PROBE_CYCLES(20),
        .ATTEMPTS    (2)
    ) lane_a_rxdetect_eq_regs_i (
        .clk                 (clk),
        .reset_n             (reset_n),
        .wr_en               (wr_en),
        .rd_en               (rd_en),
        .addr                (addr),
        .wr_data             (wr_data),
        .rd_data             (rd_data),
        .signal_present      (signal_present),
        .strap_pin_float     (strap_pin_float),
        .receiver_detect_pin (receiver_detect_pin),
        .far_end_found       (far_end_found),
        .probe               (probe),
        .term_50_ohm         (term_50_ohm),
        .eq_boost            (eq_boost),
        .short_protect_en    (short_protect_en)
    );
    far_end_model far_end_model_i (
        .clk           (clk),
        .reset_n       (reset_n),
        .probe         (probe),
        .answer_after  (answer_after),
        .far_end_found (far_end_found)
    );
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // Whole run is a few hundred cycles
    always @(posedge clk)
    begin
        if (probe) probes++;
        if (++cyc == 3000)
        begin
            num_errors++;
            final_report;
        end
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], ^(s & 32'h80200003)};
    endfunction
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Strobes stay up until the next call or wait lowers them
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        {wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
        @(posedge clk);
        #1;
        if (w && m.exists(a)) m[a] = d;
        if (!w) chk(rd_data, a == 8'h0A ? {7'h00, strap_pin_float &
            !signal_present} : m.exists(a) ? m[a] : 8'h00);
    endtask
    task wt(input logic v, input int k);
        {wr_en, rd_en} = 2'h0;
        repeat (k) @(posedge clk);
        #1 chk({7'h00, term_50_ohm}, {7'h00, v});
    endtask
    task final_report;
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        {wr_en, rd_en, addr, wr_data, answer_after} = 0;
        {signal_present, strap_pin_float, receiver_detect_pin} = 0;
        reset_n = 0;
        m = '{8'h08:8'h00, 8'h0B:8'h70, 8'h0C:8'h00, 8'h0E:8'h00,
            8'h0F:8'h2F, 8'h10:8'hED};
        repeat (12) @(posedge clk);
        #1 reset_n = 1;
        foreach (m[a]) acc(0, a, 0);
        for (int i = 0; i < 8; i++)
        begin
            {strap_pin_float, signal_present} = i[1:0];
            lf = nxt(lf);
            acc(1, 8'h0F, lf[7:0]);
            acc(1, 8'h10, lf[15:8] & 8'h87);
            acc(1, i[0] ? 8'h0A : 8'h20, lf[23:16]);
            acc(0, 8'h0A, 0);
            acc(0, 8'h20, 0);
            acc(0, 8'h0F, 0);
        end
        wt(0, 2);
        chk(eq_boost, m[8'h0F]);
        chk({7'h00, short_protect_en}, {7'h00, m[8'h10][7]});
        receiver_detect_pin = 2'h3;
        wt(1, 4);
        acc(1, 8'h08, 8'h08);
        wt(0, 4);
        acc(1, 8'h0E, 8'h0C);
        wt(1, 4);
        acc(1, 8'h0E, 8'h00);
        wt(0, 4);
        probes = 0;
        acc(1, 8'h0E, 8'h04);
        wt(0, 90);
        chk(8'(probes), 8'h02);
        acc(1, 8'h0E, 8'h00);
        {answer_after, probes} = {8'h03, 32'h0};
        acc(1, 8'h0E, 8'h08);
        wt(1, 90);
        chk(8'(probes), 8'h03);
        final_report;
    end
endmodule
